// ---- cwd_config_decode.sv ----
// Configuration word decoder with an AHB-Lite register port and a watchdog counter.
// Assumes the nonvolatile words are stable on their inputs whenever reset is released.
`default_nettype none
`timescale 1ns/1ps

module cwd_config_decode (
   // Clock and reset.
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave.
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Nonvolatile words and device mode.
   input  wire logic [15:0] nv_word_one,
   input  wire logic [15:0] nv_word_two,
   input  wire logic        sleep_mode,
   // Watchdog setup.
   output logic [7:0]       wdt_prescale_ratio,
   output logic [15:0]      wdt_postscale_ratio,
   output logic [23:0]      wdt_timeout_periods,
   output logic             wdt_enabled,
   output logic             wdt_timeout,
   // Clock start-up.
   output logic             two_speed_startup_en,
   output logic [2:0]       initial_osc_sel,
   output logic             fast_rc_divided,
   // Reference routing, 1 selects port A pins 10 and 9, 0 port B pins 0 and 1.
   output logic             cmp_vref_on_port_a,
   output logic             adc_vref_on_port_a
);

   cwd_pkg::cwd_regs_t st_r;
   cwd_pkg::cwd_regs_t st_nxt;

   logic [3:0]  wdt_postscale_sel;
   logic [1:0]  wdt_config_field;
   logic [1:0]  alt_vref_route_sel;
   logic        wdt_prescale_sel;
   logic        addr_phase;
   logic        wdt_expired;
   logic [23:0] timeout_product;

   assign wdt_prescale_sel   = st_r.word_one[cwd_pkg::CWD_W1_PRESCALE_BIT];
   assign wdt_postscale_sel  = st_r.word_one[cwd_pkg::CWD_W1_POST_LSB +: 4];
   assign wdt_config_field   = st_r.word_one[cwd_pkg::CWD_W1_WDTCFG_LSB +: 2];
   assign alt_vref_route_sel = st_r.word_two[cwd_pkg::CWD_W2_VREF_LSB +: 2];
   assign addr_phase         = hsel && htrans[1] && hready;

   always_comb begin
      wdt_prescale_ratio = wdt_prescale_sel ? cwd_pkg::CWD_PRESCALE_128
                                            : cwd_pkg::CWD_PRESCALE_32;
   end

   assign wdt_postscale_ratio = cwd_pkg::CWD_POSTSCALE_ONE << wdt_postscale_sel;

   assign timeout_product = {16'h0000, wdt_prescale_ratio} * {8'h00, wdt_postscale_ratio};
   assign wdt_timeout_periods = timeout_product;

   always_comb begin
      case (wdt_config_field)
         cwd_pkg::CWD_WDT_ALWAYS:   wdt_enabled = 1'b1;
         cwd_pkg::CWD_WDT_SOFT:     wdt_enabled = st_r.soft_wdt_enable;
         cwd_pkg::CWD_WDT_RUN_ONLY: wdt_enabled = !sleep_mode;
         default:                   wdt_enabled = 1'b0;
      endcase
   end

   assign two_speed_startup_en = st_r.word_two[cwd_pkg::CWD_W2_TWO_SPEED_BIT];

   assign initial_osc_sel = st_r.word_two[cwd_pkg::CWD_W2_OSC_LSB +: 3];
   assign fast_rc_divided = (initial_osc_sel == cwd_pkg::CWD_OSC_FRC_DIV);

   // The undocumented routing code 11 falls back to port B so no reference floats.
   always_comb begin
      case (alt_vref_route_sel)
         cwd_pkg::CWD_VREF_ALL_B: begin
            cmp_vref_on_port_a = 1'b0;
            adc_vref_on_port_a = 1'b0;
         end
         cwd_pkg::CWD_VREF_ADC_ALT: begin
            cmp_vref_on_port_a = 1'b0;
            adc_vref_on_port_a = 1'b1;
         end
         cwd_pkg::CWD_VREF_CMP_ALT: begin
            cmp_vref_on_port_a = 1'b1;
            adc_vref_on_port_a = 1'b0;
         end
         default: begin
            cmp_vref_on_port_a = 1'b0;
            adc_vref_on_port_a = 1'b0;
         end
      endcase
   end

   cwd_wdt_counter u_wdt (
      .hclk    (hclk),
      .hresetn (hresetn),
      .enable  (wdt_enabled && st_r.state == cwd_pkg::CWD_ST_RUN),
      .clear   (st_r.kick),
      .limit   (timeout_product),
      .expired (wdt_expired)
   );

   // Read data is prepared at the address phase so that it stands through the zero-wait data phase.
   always_comb begin
      st_nxt      = st_r;
      st_nxt.kick = 1'b0;
      case (st_r.state)
         cwd_pkg::CWD_ST_LOAD: begin
            st_nxt.word_one = nv_word_one;
            st_nxt.word_two = nv_word_two;
            st_nxt.state    = cwd_pkg::CWD_ST_RUN;
         end
         cwd_pkg::CWD_ST_RUN: begin
            st_nxt.state = cwd_pkg::CWD_ST_RUN;
         end
         default: begin
            st_nxt.state = cwd_pkg::CWD_ST_LOAD;
         end
      endcase
      if (st_r.dp_valid && st_r.dp_write) begin
         case (st_r.dp_addr)
            cwd_pkg::CWD_ADDR_CTRL: begin
               st_nxt.soft_wdt_enable = hwdata[cwd_pkg::CWD_CTRL_SW_EN_BIT];
               st_nxt.kick            = hwdata[cwd_pkg::CWD_CTRL_KICK_BIT];
            end
            cwd_pkg::CWD_ADDR_STATUS: begin
               if (hwdata[cwd_pkg::CWD_STAT_TMO_BIT]) begin
                  st_nxt.timeout_flag = 1'b0;
               end
            end
            default: begin
               st_nxt.timeout_flag = st_nxt.timeout_flag;
            end
         endcase
      end
      // An expiry in the same cycle as a clear keeps the flag set.
      if (wdt_expired) begin
         st_nxt.timeout_flag = 1'b1;
      end
      st_nxt.dp_valid = addr_phase;
      st_nxt.dp_write = hwrite;
      st_nxt.dp_addr  = haddr[7:0];
      st_nxt.rdata    = 32'h00000000;
      if (addr_phase && !hwrite) begin
         case (haddr[7:0])
            cwd_pkg::CWD_ADDR_WORD_ONE: begin
               st_nxt.rdata = {8'h00, cwd_pkg::CWD_UNIMPL_ONES, st_r.word_one};
            end
            cwd_pkg::CWD_ADDR_WORD_TWO: begin
               st_nxt.rdata = {8'h00, cwd_pkg::CWD_UNIMPL_ONES, st_r.word_two};
            end
            cwd_pkg::CWD_ADDR_CTRL: begin
               st_nxt.rdata[cwd_pkg::CWD_CTRL_SW_EN_BIT] = st_r.soft_wdt_enable;
            end
            cwd_pkg::CWD_ADDR_STATUS: begin
               st_nxt.rdata[cwd_pkg::CWD_STAT_ACTIVE_BIT] = wdt_enabled;
               st_nxt.rdata[cwd_pkg::CWD_STAT_TMO_BIT]    = st_r.timeout_flag;
               st_nxt.rdata[cwd_pkg::CWD_STAT_LOADED_BIT] =
                  (st_r.state == cwd_pkg::CWD_ST_RUN);
            end
            cwd_pkg::CWD_ADDR_TIMEOUT: begin
               st_nxt.rdata = {8'h00, timeout_product};
            end
            default: begin
               st_nxt.rdata = 32'h00000000;
            end
         endcase
      end
   end

   // Words reset to the erased value and are reloaded one cycle after reset is released.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r          <= '0;
         st_r.state    <= cwd_pkg::CWD_ST_LOAD;
         st_r.word_one <= cwd_pkg::CWD_WORD_RESET;
         st_r.word_two <= cwd_pkg::CWD_WORD_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign hreadyout   = 1'b1;
   assign hresp       = 1'b0;
   assign hrdata      = st_r.rdata;
   assign wdt_timeout = st_r.timeout_flag;

endmodule : cwd_config_decode

`default_nettype wire

// ---- cwd_pkg.sv ----
// Constants, register map, field positions and state types for the configuration word decoder.
// Assumes a single 40 MHz clock domain and an AHB-Lite register port.
`default_nettype none

package cwd_pkg;

   // Register byte addresses.
   localparam logic [7:0] CWD_ADDR_WORD_ONE = 8'h00;
   localparam logic [7:0] CWD_ADDR_WORD_TWO = 8'h04;
   localparam logic [7:0] CWD_ADDR_CTRL     = 8'h08;
   localparam logic [7:0] CWD_ADDR_STATUS   = 8'h0c;
   localparam logic [7:0] CWD_ADDR_TIMEOUT  = 8'h10;

   // Reset value of a configuration word before it is reloaded: erased bits read as ones.
   localparam logic [15:0] CWD_WORD_RESET   = 16'hffff;
   localparam logic [7:0]  CWD_UNIMPL_ONES  = 8'hff;

   // Word one fields.
   localparam int CWD_W1_PRESCALE_BIT = 4;
   localparam int CWD_W1_POST_LSB     = 0;
   localparam int CWD_W1_WDTCFG_LSB   = 5;

   // Word two fields.
   localparam int CWD_W2_TWO_SPEED_BIT = 15;
   localparam int CWD_W2_VREF_LSB      = 11;
   localparam int CWD_W2_OSC_LSB       = 8;

   // Control and status bit positions.
   localparam int CWD_CTRL_SW_EN_BIT  = 0;
   localparam int CWD_CTRL_KICK_BIT   = 1;
   localparam int CWD_STAT_ACTIVE_BIT = 0;
   localparam int CWD_STAT_TMO_BIT    = 1;
   localparam int CWD_STAT_LOADED_BIT = 2;

   // Decoded ratios and codes.
   localparam logic [7:0]  CWD_PRESCALE_128  = 8'h80;
   localparam logic [7:0]  CWD_PRESCALE_32   = 8'h20;
   localparam logic [15:0] CWD_POSTSCALE_ONE = 16'h0001;
   localparam logic [1:0]  CWD_VREF_ALL_B    = 2'h0;
   localparam logic [1:0]  CWD_VREF_ADC_ALT  = 2'h1;
   localparam logic [1:0]  CWD_VREF_CMP_ALT  = 2'h2;
   localparam logic [2:0]  CWD_OSC_FRC_DIV   = 3'h7;
   localparam logic [1:0]  CWD_WDT_ALWAYS    = 2'h3;
   localparam logic [1:0]  CWD_WDT_SOFT      = 2'h2;
   localparam logic [1:0]  CWD_WDT_RUN_ONLY  = 2'h1;

   // Loader states, one-hot.
   typedef enum logic [1:0] {
      CWD_ST_LOAD = 2'b01,
      CWD_ST_RUN  = 2'b10
   } cwd_state_t;

   // Whole state of the decoder.
   typedef struct packed {
      cwd_state_t  state;
      logic [15:0] word_one;
      logic [15:0] word_two;
      logic        soft_wdt_enable;
      logic        kick;
      logic        timeout_flag;
      logic        dp_valid;
      logic        dp_write;
      logic [7:0]  dp_addr;
      logic [31:0] rdata;
   } cwd_regs_t;

   // Whole state of the watchdog counter.
   typedef struct packed {
      logic [23:0] count;
      logic        expired;
   } cwd_wdt_t;

endpackage : cwd_pkg

`default_nettype wire

// ---- cwd_wdt_counter.sv ----
// Watchdog counter: counts clock periods up to a limit and pulses on expiry.
// Assumes the limit is the product of the two ratios and stays stable while counting.
`default_nettype none
`timescale 1ns/1ps

module cwd_wdt_counter (
   // Clock and reset.
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // Control.
   input  wire logic        enable,
   input  wire logic        clear,
   input  wire logic [23:0] limit,
   // Result.
   output logic             expired
);

   cwd_pkg::cwd_wdt_t st_r;
   cwd_pkg::cwd_wdt_t st_nxt;

   always_comb begin
      st_nxt         = st_r;
      st_nxt.expired = 1'b0;
      if (clear || !enable) begin
         st_nxt.count = 24'h000000;
      end else if (st_r.count == limit - 24'h000001) begin
         st_nxt.count   = 24'h000000;
         st_nxt.expired = 1'b1;
      end else begin
         st_nxt.count = st_r.count + 24'h000001;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign expired = st_r.expired;

endmodule : cwd_wdt_counter

`default_nettype wire

// ---- cwd_checker.sv ----
// Assertion checker for the configuration word decoder, bound to its top module.
// Assumes the nonvolatile words are steady at the first edge after reset release.
`default_nettype none
`timescale 1ns/1ps
module cwd_checker (
   // Clock, reset and bus.
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   // Words and decoded outputs.
   input wire logic [15:0] nv_word_one,
   input wire logic [15:0] nv_word_two,
   input wire logic [7:0]  wdt_prescale_ratio,
   input wire logic [15:0] wdt_postscale_ratio,
   input wire logic [23:0] wdt_timeout_periods,
   input wire logic        wdt_enabled,
   input wire logic        two_speed_startup_en,
   input wire logic [2:0]  initial_osc_sel,
   input wire logic        fast_rc_divided,
   input wire logic        cmp_vref_on_port_a,
   input wire logic        adc_vref_on_port_a
);
   // An own copy of the words keeps the checks independent of the decoder's registers.
   logic        up_r;
   logic [15:0] w1_r;
   logic [15:0] w2_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         up_r <= 1'b0;
         w1_r <= 16'hffff;
         w2_r <= 16'hffff;
      end else if (!up_r) begin
         up_r <= 1'b1;
         w1_r <= nv_word_one;
         w2_r <= nv_word_two;
      end
   end
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence word_read;
      up_r && hsel && htrans[1] && hready && !hwrite && haddr[7:3] == 5'h00;
   endsequence
   chk_prescale_ratio: assert property (up_r |->
      wdt_prescale_ratio == (w1_r[4] ? 8'h80 : 8'h20)) else $error("prescale ratio wrong");
   chk_postscale_ratio: assert property (up_r |->
      wdt_postscale_ratio == 16'h0001 << w1_r[3:0]) else $error("postscale ratio wrong");
   chk_two_speed: assert property (up_r |->
      two_speed_startup_en == w2_r[15]) else $error("two-speed start-up wrong");
   chk_vref_all_b: assert property (up_r && w2_r[12:11] == 2'b00 |->
      !cmp_vref_on_port_a && !adc_vref_on_port_a) else $error("routing 00 wrong");
   chk_vref_adc_alt: assert property (up_r && w2_r[12:11] == 2'b01 |->
      !cmp_vref_on_port_a && adc_vref_on_port_a) else $error("routing 01 wrong");
   chk_vref_cmp_alt: assert property (up_r && w2_r[12:11] == 2'b10 |->
      cmp_vref_on_port_a && !adc_vref_on_port_a) else $error("routing 10 wrong");
   chk_word_upper_ones: assert property (word_read |=>
      hrdata[23:16] == 8'hff) else $error("word upper bits not ones");
   chk_initial_osc: assert property (up_r |-> initial_osc_sel == w2_r[10:8] &&
      fast_rc_divided == (w2_r[10:8] == 3'h7)) else $error("initial oscillator wrong");
   chk_wdt_always_on: assert property (up_r && w1_r[6:5] == 2'b11 |->
      wdt_enabled [*4]) else $error("watchdog not held on");
   chk_timeout_product: assert property (up_r |->
      wdt_timeout_periods == 24'(w1_r[4] ? 8'h80 : 8'h20) << w1_r[3:0])
      else $error("timeout product wrong");
endmodule : cwd_checker
bind cwd_config_decode cwd_checker u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
   .hready, .hrdata, .nv_word_one, .nv_word_two, .wdt_prescale_ratio, .wdt_postscale_ratio,
   .wdt_timeout_periods, .wdt_enabled, .two_speed_startup_en, .initial_osc_sel,
   .fast_rc_divided, .cmp_vref_on_port_a, .adc_vref_on_port_a);
`default_nettype wire

// ---- tb_config_word_wdt_osc_decode.sv ----
// Self-checking testbench for the configuration word decoder.
// Assumes one slave on the bus, so its ready output is the bus ready.
`default_nettype none
`timescale 1ns/1ps
module tb_config_word_wdt_osc_decode;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, sleep_mode, wdt_enabled, wdt_timeout;
   logic two_speed_startup_en, fast_rc_divided, cmp_vref_on_port_a, adc_vref_on_port_a;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [15:0] nv_word_one, nv_word_two, wa, wb, wdt_postscale_ratio;
   logic [7:0]  wdt_prescale_ratio;
   logic [23:0] wdt_timeout_periods;
   logic [2:0]  initial_osc_sel;
   int          num_errors = 0;
   int          n_compared = 0;
   cwd_config_decode dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .nv_word_one, .nv_word_two,
      .sleep_mode, .wdt_prescale_ratio, .wdt_postscale_ratio, .wdt_timeout_periods,
      .wdt_enabled, .wdt_timeout, .two_speed_startup_en, .initial_osc_sel, .fast_rc_divided,
      .cmp_vref_on_port_a, .adc_vref_on_port_a);
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   function automatic logic [31:0] tmo(input logic [15:0] w);
      return (w[4] ? 32'h80 : 32'h20) << w[3:0];
   endfunction : tmo
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // Single transfer; the address phase is held until ready is seen high.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic restart(input logic [15:0] a, input logic [15:0] b);
      hresetn     <= 1'b0;
      nv_word_one <= a;
      nv_word_two <= b;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
   endtask : restart
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test
   initial begin
      #100us;
      num_errors++;
      end_of_test();
   end
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      nv_word_one = 16'hffff;
      nv_word_two = 16'hffff;
      sleep_mode = 1'b0;
      void'($urandom(32'hd34d1ee2));
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      // Every postscaler, routing and oscillator code, the rest random.
      for (int i = 0; i < 16; i++) begin
         wa = 16'($urandom);
         wb = 16'($urandom);
         wa[3:0] = 4'(i);
         wb[12:11] = 2'(i);
         wb[10:8] = 3'(i);
         sleep_mode <= 1'($urandom);
         restart(wa, wb);
         check(32'(wdt_prescale_ratio), wa[4] ? 32'h80 : 32'h20);
         check(32'(wdt_postscale_ratio), 32'h1 << wa[3:0]);
         check(32'(two_speed_startup_en), 32'(wb[15]));
         check(32'({cmp_vref_on_port_a, adc_vref_on_port_a}), 32'(wb[12] ^ wb[11] ? wb[12:11] : 2'b00));
         check(32'({initial_osc_sel, fast_rc_divided}), 32'({wb[10:8], wb[10:8] == 3'h7}));
         if (wa[6:5] != 2'b10) check(32'(wdt_enabled), 32'(wa[5] & (wa[6] | !sleep_mode)));
         check(32'(wdt_timeout_periods), tmo(wa));
         bus(1'b0, 8'h00, 32'h0);
         check(rd, {16'h00ff, wa});
         bus(1'b0, 8'h04, 32'h0);
         check(rd, {16'h00ff, wb});
         check(32'(hresp), 32'h0);
         bus(1'b0, 8'h10, 32'h0);
         check(rd, tmo(wa));
         $display("decode test %0d done", i);
      end
      // Software control only counts for code 10; code 11 ignores it.
      restart(16'h0040, 16'hffff);
      bus(1'b1, 8'h08, 32'h1);
      bus(1'b0, 8'h0c, 32'h0);
      check(32'(rd[0]), 32'h1);
      bus(1'b1, 8'h08, 32'h0);
      bus(1'b0, 8'h0c, 32'h0);
      check(32'(rd[0]), 32'h0);
      restart(16'h0060, 16'hffff);
      bus(1'b1, 8'h08, 32'h0);
      bus(1'b1, 8'h0c, 32'h2);
      bus(1'b1, 8'h08, 32'h2);
      // A ratio of 32 by 1 must expire between 20 and 40 cycles after the kick.
      repeat (20) @(posedge hclk);
      check(32'(wdt_timeout), 32'h0);
      repeat (20) @(posedge hclk);
      check(32'(wdt_timeout), 32'h1);
      bus(1'b1, 8'h00, 32'h0);
      bus(1'b0, 8'h00, 32'h0);
      check(rd, 32'h00ff0060);
      bus(1'b0, 8'h20, 32'h0);
      check(rd, 32'h0);
      // The next expiry is far off, so clearing the sticky flag now must leave active and loaded.
      bus(1'b1, 8'h0c, 32'h2);
      bus(1'b0, 8'h0c, 32'h0);
      check(rd, 32'h5);
      $display("watchdog test done");
      end_of_test();
   end
endmodule : tb_config_word_wdt_osc_decode
`default_nettype wire
